// ===== pkg/pie_defs.svh
// register offsets, field positions, reset values for the second enable register
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH
`define PIE_EN_OFFSET 16'hE20C
`define PIE_ST_OFFSET 16'hE280
`define PIE_RAW_OFFSET 16'hE284
`define PIE_PEND_OFFSET 16'hE288
`define PIE_SRC_W 26
`define PIE_EN_RESET 26'h0000000
`define PIE_ST_RESET 26'h0000000
`define PIE_RSVD_ZERO 6'h00
`define PIE_B_U4_LINE 25
`define PIE_B_U4_RX 24
`define PIE_B_U4_TXE 23
`define PIE_B_U3_LINE 22
`define PIE_B_U3_RX 21
`define PIE_B_U3_TXE 20
`define PIE_B_U2_LINE 19
`define PIE_B_U2_RX 18
`define PIE_B_U2_TXE 17
`define PIE_B_U1_MODEM 16
`define PIE_B_U1_LINE 15
`define PIE_B_U1_RX 14
`define PIE_B_U1_TXE 13
`define PIE_B_MGMT 12
`define PIE_B_SPI 11
`define PIE_B_AUD_TX 10
`define PIE_B_AUD_RX 9
`define PIE_B_TWO_WIRE 8
`define PIE_B_TIMER1 7
`define PIE_B_TIMER0 6
`define PIE_B_EXT3 5
`define PIE_B_EXT2 4
`define PIE_B_EXT1 3
`define PIE_B_EXT0 2
`define PIE_B_CC_TX 1
`define PIE_B_CC_RX 0
`endif

// ===== pkg/pie_pkg.sv
// types shared by the second interrupt enable block
package pie_pkg;
    // enable fields, most significant first
    typedef struct packed {
        logic uart_four_line_err_en;
        logic uart_four_rx_level_en;
        logic uart_four_tx_empty_en;
        logic uart_three_line_err_en;
        logic uart_three_rx_level_en;
        logic uart_three_tx_empty_en;
        logic uart_two_line_err_en;
        logic uart_two_rx_level_en;
        logic uart_two_tx_empty_en;
        logic uart_one_modem_en;
        logic uart_one_line_err_en;
        logic uart_one_rx_level_en;
        logic uart_one_tx_empty_en;
        logic mgmt_serial_irq_en;
        logic serial_periph_irq_en;
        logic audio_tx_irq_en;
        logic audio_rx_irq_en;
        logic two_wire_irq_en;
        logic timer_one_irq_en;
        logic timer_zero_irq_en;
        logic ext_irq_three_en;
        logic ext_irq_two_en;
        logic ext_irq_one_en;
        logic ext_irq_zero_en;
        logic comm_chan_tx_en;
        logic comm_chan_rx_en;
    } pie_enable_s;
    // one register access as seen by the decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } pie_access_s;
endpackage

// ===== verilog/pie_enable_two.sv
// second interrupt enable register with sticky status and level interrupt
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "pie_defs.svh"

module pie_enable_two
#(
    parameter int ADDR_W = 16
)
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [`PIE_SRC_W-1:0] src_in,
    output logic [31:0] rd_data_out,
    output logic [`PIE_SRC_W-1:0] en_vec_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check
    generate
        if (ADDR_W < 16 || ADDR_W > 32)
        begin : g_bad_addr
            $error("ADDR_W must lie between 16 and 32");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    pie_pkg::pie_enable_s en_reg;
    pie_pkg::pie_enable_s en_next;
    pie_pkg::pie_access_s acc;
    logic [`PIE_SRC_W-1:0] status_reg;
    logic [`PIE_SRC_W-1:0] status_next;
    logic [`PIE_SRC_W-1:0] src_prev_reg;
    logic [`PIE_SRC_W-1:0] src_edge;
    logic [`PIE_SRC_W-1:0] pending;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic irq_reg;
    logic sel_en;
    logic sel_st;
    logic sel_raw;
    logic sel_pend;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    assign acc = '{wr: wr_in, rd: rd_in, wdata: wr_data_in};
    assign sel_en = (addr_in == ADDR_W'(`PIE_EN_OFFSET));
    assign sel_st = (addr_in == ADDR_W'(`PIE_ST_OFFSET));
    assign sel_raw = (addr_in == ADDR_W'(`PIE_RAW_OFFSET));
    assign sel_pend = (addr_in == ADDR_W'(`PIE_PEND_OFFSET));

    ////////////////////////////////////////////////////////////////////////////
    // enable register next value, one field per bit
    always_comb
    begin
        en_next = en_reg;
        if (acc.wr && sel_en)
        begin
            en_next.uart_four_line_err_en = acc.wdata[`PIE_B_U4_LINE];
            en_next.uart_four_rx_level_en = acc.wdata[`PIE_B_U4_RX];
            en_next.uart_four_tx_empty_en = acc.wdata[`PIE_B_U4_TXE];
            en_next.uart_three_line_err_en = acc.wdata[`PIE_B_U3_LINE];
            en_next.uart_three_rx_level_en = acc.wdata[`PIE_B_U3_RX];
            en_next.uart_three_tx_empty_en = acc.wdata[`PIE_B_U3_TXE];
            en_next.uart_two_line_err_en = acc.wdata[`PIE_B_U2_LINE];
            en_next.uart_two_rx_level_en = acc.wdata[`PIE_B_U2_RX];
            en_next.uart_two_tx_empty_en = acc.wdata[`PIE_B_U2_TXE];
            en_next.uart_one_modem_en = acc.wdata[`PIE_B_U1_MODEM];
            en_next.uart_one_line_err_en = acc.wdata[`PIE_B_U1_LINE];
            en_next.uart_one_rx_level_en = acc.wdata[`PIE_B_U1_RX];
            en_next.uart_one_tx_empty_en = acc.wdata[`PIE_B_U1_TXE];
            en_next.mgmt_serial_irq_en = acc.wdata[`PIE_B_MGMT];
            en_next.serial_periph_irq_en = acc.wdata[`PIE_B_SPI];
            en_next.audio_tx_irq_en = acc.wdata[`PIE_B_AUD_TX];
            en_next.audio_rx_irq_en = acc.wdata[`PIE_B_AUD_RX];
            en_next.two_wire_irq_en = acc.wdata[`PIE_B_TWO_WIRE];
            en_next.timer_one_irq_en = acc.wdata[`PIE_B_TIMER1];
            en_next.timer_zero_irq_en = acc.wdata[`PIE_B_TIMER0];
            en_next.ext_irq_three_en = acc.wdata[`PIE_B_EXT3];
            en_next.ext_irq_two_en = acc.wdata[`PIE_B_EXT2];
            en_next.ext_irq_one_en = acc.wdata[`PIE_B_EXT1];
            en_next.ext_irq_zero_en = acc.wdata[`PIE_B_EXT0];
            en_next.comm_chan_tx_en = acc.wdata[`PIE_B_CC_TX];
            en_next.comm_chan_rx_en = acc.wdata[`PIE_B_CC_RX];
        end
    end

    // enable register, write bits 31..26 have no storage
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            en_reg <= `PIE_EN_RESET;
        end
        else
        begin
            en_reg <= en_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source edge detect; sources share this clock so no synchroniser
    assign src_edge = src_in & ~src_prev_reg;

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            src_prev_reg <= `PIE_ST_RESET;
        end
        else
        begin
            src_prev_reg <= src_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status, cleared by a read; a new edge in that cycle survives
    always_comb
    begin
        status_next = status_reg;
        if (acc.rd && sel_st)
        begin
            status_next = '0;
        end
        status_next = status_next | src_edge;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            status_reg <= `PIE_ST_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt line, registered, high the cycle after any enabled status bit is set
    assign pending = status_reg & en_reg;

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, unmapped addresses and reserved bits read zero
    always_comb
    begin
        rd_data_next = 32'h00000000;
        if (acc.rd)
        begin
            if (sel_en)
            begin
                rd_data_next = {`PIE_RSVD_ZERO, en_reg};
            end
            else if (sel_st)
            begin
                rd_data_next = {`PIE_RSVD_ZERO, status_reg};
            end
            else if (sel_raw)
            begin
                rd_data_next = {`PIE_RSVD_ZERO, src_prev_reg};
            end
            else if (sel_pend)
            begin
                rd_data_next = {`PIE_RSVD_ZERO, pending};
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            rd_data_reg <= 32'h00000000;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign rd_data_out = rd_data_reg;
    assign en_vec_out = en_reg;
    assign irq_out = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // a write to the enable word lands in the next cycle
    AST_U4_LINE_ERR:
        assert property ((wr_in && sel_en) |=> en_reg[`PIE_B_U4_LINE] == $past(wr_data_in[25]))
        else $error("uart four line error enable did not load");

    AST_U4_RX_LEVEL:
        assert property ((wr_in && sel_en) |=> en_vec_out[`PIE_B_U4_RX] == $past(wr_data_in[24]))
        else $error("uart four rx level enable did not load");

    // a masked transmitter empty status never raises the line
    AST_U4_TXE_OFF:
        assert property ((status_reg == 26'h0800000 && !en_reg[`PIE_B_U4_TXE]) |=> !irq_out)
        else $error("disabled uart four tx empty raised the interrupt");

    // an enabled audio transmit status raises the line
    AST_AUD_TX_ON:
        assert property ((status_reg[`PIE_B_AUD_TX] && en_reg[`PIE_B_AUD_TX]) |=> irq_out)
        else $error("enabled audio transmit status did not interrupt");

    // enables hold unless the enable word is written
    AST_EN_HOLD:
        assert property (!(wr_in && sel_en) |=> $stable(en_vec_out))
        else $error("enable word changed without a write");

    // the whole stored word follows the write data
    AST_EN_WORD:
        assert property ((wr_in && sel_en) |=> en_vec_out == $past(wr_data_in[25:0]))
        else $error("enable word differs from written data");

    AST_IRQ_ON:
        assert property ((|(status_reg & en_reg)) |=> irq_out)
        else $error("interrupt missing while an enabled status is set");

    AST_IRQ_OFF:
        assert property ((!(|(status_reg & en_reg))) |=> !irq_out)
        else $error("interrupt raised with nothing enabled and pending");

    // reserved bits read zero and the rest mirror the enables
    AST_RSVD_READ:
        assert property ((rd_in && sel_en) |=> rd_data_out == {6'h00, $past(en_vec_out)})
        else $error("enable read returned wrong data");

    // reset empties the enables for at least the following cycle
    AST_RESET_CLEAR:
        assert property (@(posedge core_clk_in) disable iff (1'b0)
            rst_in |=> (en_vec_out == 26'h0000000 && !irq_out))
        else $error("reset did not clear enables");

    // a rising communications receive source (bit 0) is never lost, even during a status read
    AST_EDGE_KEPT:
        assert property ((src_in[0] && !src_prev_reg[0]) |=> status_reg[0])
        else $error("communications receive event lost");

    // a status read clears every bit with no new edge
    AST_STATUS_CLEAR:
        assert property ((rd_in && sel_st && src_edge == 26'h0000000) |=> status_reg == 26'h0)
        else $error("status read did not clear");

    // an event in the cycle of a status read survives the clear
    AST_STATUS_SET_WINS:
        assert property ((rd_in && sel_st) |=> status_reg == $past(src_edge))
        else $error("edge during status read was lost");

    // without a status read the status only gains new edges
    AST_STATUS_FOLLOW:
        assert property (!(rd_in && sel_st) |=>
            status_reg == ($past(status_reg) | $past(src_edge)))
        else $error("status changed without an edge or a read");

    // every field group loads from its own write data bits
    AST_U3_FIELDS:
        assert property ((wr_in && sel_en) |=>
            en_vec_out[`PIE_B_U3_LINE:`PIE_B_U3_TXE] == $past(wr_data_in[22:20]))
        else $error("uart three enables did not load");

    AST_U2_FIELDS:
        assert property ((wr_in && sel_en) |=>
            en_vec_out[`PIE_B_U2_LINE:`PIE_B_U2_TXE] == $past(wr_data_in[19:17]))
        else $error("uart two enables did not load");

    AST_U1_FIELDS:
        assert property ((wr_in && sel_en) |=>
            en_vec_out[`PIE_B_U1_MODEM:`PIE_B_U1_TXE] == $past(wr_data_in[16:13]))
        else $error("uart one enables did not load");

    AST_PERIPH_FIELDS:
        assert property ((wr_in && sel_en) |=>
            en_vec_out[`PIE_B_MGMT:`PIE_B_TWO_WIRE] == $past(wr_data_in[12:8]))
        else $error("peripheral enables did not load");

    AST_TIMER_EXT_FIELDS:
        assert property ((wr_in && sel_en) |=>
            en_vec_out[`PIE_B_TIMER1:`PIE_B_EXT0] == $past(wr_data_in[7:2]))
        else $error("timer or external enables did not load");

    AST_CC_FIELDS:
        assert property ((wr_in && sel_en) |=>
            en_vec_out[`PIE_B_CC_TX:`PIE_B_CC_RX] == $past(wr_data_in[1:0]))
        else $error("communications channel enables did not load");

    // read data stands one cycle only, zero otherwise
    AST_RD_IDLE_ZERO:
        assert property (!rd_in |=> rd_data_out == 32'h00000000)
        else $error("read data present without a read");

    // unmapped addresses read zero
    AST_UNMAPPED_READ:
        assert property ((rd_in && !(sel_en || sel_st || sel_raw || sel_pend)) |=>
            rd_data_out == 32'h00000000)
        else $error("unmapped read returned data");

    // reserved top bits never carry data
    AST_RSVD_BITS:
        assert property (rd_data_out[31:26] == `PIE_RSVD_ZERO)
        else $error("reserved read bits not zero");

    COV_ENABLE_WRITE:
        cover property ((wr_in && sel_en && wr_data_in[25:0] != 26'h0) ##1 en_vec_out != 26'h0);

    COV_IRQ_RAISE:
        cover property ($rose(src_in[`PIE_B_TIMER0]) ##1 status_reg[`PIE_B_TIMER0] ##1 irq_out);

    COV_CLEAR_COLLIDE:
        cover property (rd_in && sel_st && |src_edge);

    COV_RAW_READ:
        cover property (rd_in && sel_raw && |src_prev_reg);

endmodule

// ===== testbench/pie_src_model.sv
// peripheral source lines and core interrupt input facing the enable block
`timescale 1ns/100ps

module pie_src_model
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [25:0] fire_in,
    input wire logic irq_in,
    output logic [25:0] src_out,
    output logic [7:0] irq_edges_out
);
    logic [25:0] fire_reg;
    logic irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // each request holds its source line high one cycle longer than the request, then drops it
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            fire_reg <= 26'h0000000;
            src_out <= 26'h0000000;
        end
        else
        begin
            fire_reg <= fire_in;
            src_out <= fire_in | fire_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core side counts each rise of the level interrupt
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            irq_reg <= 1'b0;
            irq_edges_out <= 8'h00;
        end
        else
        begin
            irq_reg <= irq_in;
            if (irq_in && !irq_reg)
            begin
                irq_edges_out <= irq_edges_out + 8'h01;
            end
        end
    end
endmodule

// ===== testbench/pie_enable_two_test.sv
// self-checking bench for the second interrupt enable register
`timescale 1ns/100ps
`include "pie_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module pie_enable_two_test;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [25:0] fire = 26'h0000000;
    logic [25:0] src;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [25:0] en_vec;
    logic irq;
    logic [7:0] irq_edges;
    int n_errors = 0;
    int checks_done = 0;

    pie_enable_two i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .src_in(src), .rd_data_out(rdata),
        .en_vec_out(en_vec), .irq_out(irq));
    pie_src_model i_src (.core_clk_in(core_clk_in), .rst_in(rst_in), .fire_in(fire),
        .irq_in(irq), .src_out(src), .irq_edges_out(irq_edges));

    ////////////////////////////////////////////////////////////////////////
    // clock at 50 MHz
    initial
    begin
        forever #10 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus cycles, source pulses and bounded waits
    task automatic bus_wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic pulse_src(input logic [25:0] bits);
        @(posedge core_clk_in);
        fire <= bits;
        @(posedge core_clk_in);
        fire <= 26'h0000000;
        repeat (6) @(posedge core_clk_in);
        #1;
    endtask

    task automatic wait_irq(input int limit);
        int k;
        k = 0;
        while (irq !== 1'b1 && k < limit)
        begin
            @(posedge core_clk_in);
            #1;
            k++;
        end
        if (irq !== 1'b1)
        begin
            n_errors++;
            $display("BAD %0t interrupt never rose", $time);
            tally_and_finish();
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        bus_rd(`PIE_EN_OFFSET, d);
        `CHK(d, 32'h00000000)
        `CHK({en_vec, irq}, 27'h0000000)
    endtask

    task automatic t_walk;
        for (int i = 0; i < 26; i++)
        begin
            bus_wr(`PIE_EN_OFFSET, 32'h00000001 << i);
            `CHK(en_vec, 26'h0000001 << i)
            bus_rd(`PIE_EN_OFFSET, d);
            `CHK(d, 32'h00000001 << i)
        end
        `CHK(d[25], 1'b1)
    endtask

    task automatic t_reserved;
        bus_wr(`PIE_EN_OFFSET, 32'hFFFFFFFF);
        bus_wr(16'hE208, 32'h00000000);
        bus_rd(`PIE_EN_OFFSET, d);
        `CHK(d, 32'h03FFFFFF)
        bus_rd(16'hE208, d);
        `CHK(d, 32'h00000000)
    endtask

    task automatic t_back_to_back;
        @(posedge core_clk_in);
        addr <= `PIE_EN_OFFSET;
        wdata <= 32'h02AAAAAA;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 32'h02AAAAAA)
        @(posedge core_clk_in);
        #1;
        `CHK(rdata, 32'h00000000)
        bus_wr(`PIE_EN_OFFSET, 32'h00000000);
    endtask

    // a source edge in the cycle of a status read still sets, raw levels readable
    task automatic t_raw_collide;
        @(posedge core_clk_in);
        fire <= 26'h0000021;
        addr <= `PIE_ST_OFFSET;
        @(posedge core_clk_in);
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 32'h00000000)
        bus_rd(`PIE_ST_OFFSET, d);
        `CHK(d, 32'h00000021)
        bus_rd(`PIE_RAW_OFFSET, d);
        `CHK(d, 32'h00000021)
        bus_rd(`PIE_ST_OFFSET, d);
        `CHK(d, 32'h00000000)
        `CHK(irq, 1'b0)
        @(posedge core_clk_in);
        fire <= 26'h0000000;
        repeat (4) @(posedge core_clk_in);
        bus_rd(`PIE_RAW_OFFSET, d);
        `CHK(d, 32'h00000000)
    endtask

    // a reset in mid-run clears enables that were set
    task automatic t_mid_reset;
        bus_wr(`PIE_EN_OFFSET, 32'h03FFFFFF);
        `CHK(en_vec, 26'h3FFFFFF)
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_reset();
    endtask

    task automatic t_irq;
        bus_wr(`PIE_EN_OFFSET, 32'h00000040);
        pulse_src(26'h0000080);
        `CHK(irq, 1'b0)
        pulse_src(26'h0000040);
        wait_irq(8);
        bus_rd(`PIE_PEND_OFFSET, d);
        `CHK(d, 32'h00000040)
        bus_rd(`PIE_ST_OFFSET, d);
        `CHK(d, 32'h000000C0)
        repeat (2) @(posedge core_clk_in);
        #1;
        `CHK(irq, 1'b0)
        bus_wr(`PIE_EN_OFFSET, 32'h00000000);
        pulse_src(26'h0000040);
        `CHK(irq, 1'b0)
        bus_wr(`PIE_EN_OFFSET, 32'h00000040);
        wait_irq(4);
        bus_rd(`PIE_ST_OFFSET, d);
        `CHK(d, 32'h00000040)
        repeat (2) @(posedge core_clk_in);
        #1;
        `CHK({irq, irq_edges}, 9'h002)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_walk();
        t_reserved();
        t_back_to_back();
        t_irq();
        t_raw_collide();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
